// ==== logic/gcr_regs.sv ====
/*
  Register group holding the range-enhancer and level-controller settings
  and the per-channel input and serial-slot enables, with the decoded gain
  settings and slot drive enables derived from them.
  Assumes requests come from control-port logic on the same clock, one
  access per cycle, with the enhancer-or-leveler selector held elsewhere.
*/
`timescale 1ns/10ps
`include "gcr_map.svh"

// Notes on behaviour
// [R1] Threshold codes 0 to 9 select -12 dB down to -66 dB of input level.
// [R2] The host must not program threshold codes 10 to 15.
// [R3] Enhancer ceiling codes 0 to 12 select 2 dB up to 26 dB of gain.
// [R4] The host must not write enhancer ceiling codes 13 to 15.
// [R5] The enhancer register resets to threshold 7 and ceiling 0xb.
// [R6] Target codes 0 to 15 select -6 dB down to -36 dB of output level.
// [R7] Leveler ceiling codes 0 to 13 select 3 dB up to 42 dB of gain.
// [R8] The host must not write leveler ceiling codes 14 or 15.
// [R9] The leveler register resets to target 0xe high and ceiling 7 low.
// [R10] Input channels 1 to 4 reset enabled and a written 0 disables them.
// [R11] Input channels 5 to 8 are pulse-density only and reset disabled.
// [R12] Input enables run channel 1 at bit 7 to channel 8 at bit 0, 0xf0.
// [R13] Slot enables run channel 1 at bit 7 to channel 8 at bit 0, all 0.
// [R14] A slot whose enable is 0 is left undriven, with 1 it is driven.
// [R15] The selector picks the enhancer with 0 and the leveler with 1.
// [R16] Intermediate codes follow the uniform step of the end codes.
// [R17] Writes store on the clock and reads return the last value written.
module gcr_regs (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // register port
  input  wire gcr_pkg::gcr_req_s  req_in,
  output logic [7:0]              rdata_out,
  output logic                    rvalid_out,
  // selector from the neighbouring register
  input  wire logic               level_ctl_sel_in,
  // configuration outputs
  output gcr_pkg::gcr_regs_s      regs_out,
  output gcr_pkg::gcr_gain_s      gain_out,
  output logic [7:0]              input_ch_enable_out,
  output logic [7:0]              slot_oe_out
);

  gcr_pkg::gcr_regs_s regs;
  gcr_pkg::gcr_regs_s next_regs;
  logic [7:0]         next_rdata;
  logic               next_rvalid;
  gcr_pkg::gcr_gain_s next_gain;
  logic [7:0]         next_ch_en;
  logic [7:0]         next_slot_oe;
  logic [3:0]         re_thr;
  logic [3:0]         re_ceil;
  logic [3:0]         lc_tgt;
  logic [3:0]         lc_ceil;

  assign re_thr  = regs.range_enh_cfg[`GCR_HI_NIB_MSB:`GCR_HI_NIB_LSB];
  assign re_ceil = regs.range_enh_cfg[`GCR_LO_NIB_MSB:`GCR_LO_NIB_LSB];
  assign lc_tgt  = regs.level_ctl_cfg[`GCR_HI_NIB_MSB:`GCR_HI_NIB_LSB];
  assign lc_ceil = regs.level_ctl_cfg[`GCR_LO_NIB_MSB:`GCR_LO_NIB_LSB];

  // register writes and reads
  always_comb begin
    next_regs   = regs;
    next_rdata  = 8'h00;
    next_rvalid = req_in.rd;
    if (req_in.wr) begin
      unique case (req_in.addr)
        `GCR_OFS_RANGE_ENH_CFG: next_regs.range_enh_cfg = req_in.wdata; // [R17]
        `GCR_OFS_LEVEL_CTL_CFG: next_regs.level_ctl_cfg = req_in.wdata; // [R17]
        `GCR_OFS_INPUT_CH_EN:   next_regs.input_ch_en   = req_in.wdata; // [R10]
        `GCR_OFS_SLOT_OUT_EN:   next_regs.slot_out_en   = req_in.wdata; // [R13]
        default: begin
          // unmapped writes are dropped
          next_regs = regs;
        end
      endcase
    end
    // a read in the same cycle as a write returns the older value
    if (req_in.rd) begin
      unique case (req_in.addr)
        `GCR_OFS_RANGE_ENH_CFG: next_rdata = regs.range_enh_cfg; // [R17]
        `GCR_OFS_LEVEL_CTL_CFG: next_rdata = regs.level_ctl_cfg; // [R17]
        `GCR_OFS_INPUT_CH_EN:   next_rdata = regs.input_ch_en; // [R12]
        `GCR_OFS_SLOT_OUT_EN:   next_rdata = regs.slot_out_en; // [R13]
        default:                next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      regs.range_enh_cfg <= `GCR_RST_RANGE_ENH_CFG; // [R5]
      regs.level_ctl_cfg <= `GCR_RST_LEVEL_CTL_CFG; // [R9]
      regs.input_ch_en   <= `GCR_RST_INPUT_CH_EN; // [R10] [R11] [R12]
      regs.slot_out_en   <= `GCR_RST_SLOT_OUT_EN; // [R13]
      rdata_out          <= 8'h00;
      rvalid_out         <= 1'b0;
    end else begin
      regs       <= next_regs;
      rdata_out  <= next_rdata;
      rvalid_out <= next_rvalid;
    end
  end

  // decoded gain settings for the selected function
  always_comb begin
    next_gain.level_ctl_sel = level_ctl_sel_in; // [R15]
    if (level_ctl_sel_in) begin
      next_gain.level_db = 7'(`GCR_LC_TGT_BASE_DB
                         + `GCR_LC_TGT_STEP_DB * {3'h0, lc_tgt}); // [R6] [R16]
      next_gain.ceiling_db = 7'(`GCR_LC_CEIL_BASE_DB
                         + `GCR_LC_CEIL_STEP_DB * {3'h0, lc_ceil}); // [R7] [R16]
      // reserved codes are flagged, not clamped, so software sees its slip
      next_gain.reserved_code = (lc_ceil > `GCR_LC_CEIL_MAX_CODE); // [R8]
    end else begin
      next_gain.level_db = 7'(`GCR_RE_THR_BASE_DB
                         + `GCR_RE_THR_STEP_DB * {3'h0, re_thr}); // [R1] [R16]
      next_gain.ceiling_db = 7'(`GCR_RE_CEIL_BASE_DB
                         + `GCR_RE_CEIL_STEP_DB * {3'h0, re_ceil}); // [R3] [R16]
      next_gain.reserved_code = (re_thr > `GCR_RE_THR_MAX_CODE)
                              | (re_ceil > `GCR_RE_CEIL_MAX_CODE); // [R2] [R4]
    end
  end

  // per-channel outputs in channel order: index 0 is channel 1
  for (genvar ch = 0; ch < 8; ch++) begin : g_ch
    assign next_ch_en[ch]   = regs.input_ch_en[7 - ch]; // [R12]
    assign next_slot_oe[ch] = regs.slot_out_en[7 - ch]; // [R14]
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      regs_out            <= '0;
      gain_out            <= '0;
      input_ch_enable_out <= 8'h00;
      slot_oe_out         <= 8'h00;
    end else begin
      regs_out            <= regs;
      gain_out            <= next_gain;
      input_ch_enable_out <= next_ch_en;
      slot_oe_out         <= next_slot_oe;
    end
  end

endmodule

// ==== logic/gcr_map.svh ====
/*
  Offsets, field positions and reset values of the gain-control and
  channel-enable register group.
  Assumes it is included by bare name from the design.
*/
`ifndef GCR_MAP_SVH
`define GCR_MAP_SVH

// register offsets on the control port
`define GCR_OFS_RANGE_ENH_CFG   8'h6d
`define GCR_OFS_LEVEL_CTL_CFG   8'h70
`define GCR_OFS_INPUT_CH_EN     8'h73
`define GCR_OFS_SLOT_OUT_EN     8'h74

// reset values
`define GCR_RST_RANGE_ENH_CFG   8'h7b
`define GCR_RST_LEVEL_CTL_CFG   8'he7
`define GCR_RST_INPUT_CH_EN     8'hf0
`define GCR_RST_SLOT_OUT_EN     8'h00

// field positions: level/threshold in the upper nibble, ceiling below
`define GCR_HI_NIB_MSB          7
`define GCR_HI_NIB_LSB          4
`define GCR_LO_NIB_MSB          3
`define GCR_LO_NIB_LSB          0

// highest legal codes
`define GCR_RE_THR_MAX_CODE     4'h9
`define GCR_RE_CEIL_MAX_CODE    4'hc
`define GCR_LC_CEIL_MAX_CODE    4'hd

// decode: value in dB = base + step * code
`define GCR_RE_THR_BASE_DB      7'h0c
`define GCR_RE_THR_STEP_DB      7'h06
`define GCR_RE_CEIL_BASE_DB     7'h02
`define GCR_RE_CEIL_STEP_DB     7'h02
`define GCR_LC_TGT_BASE_DB      7'h06
`define GCR_LC_TGT_STEP_DB      7'h02
`define GCR_LC_CEIL_BASE_DB     7'h03
`define GCR_LC_CEIL_STEP_DB     7'h03

`endif

// ==== logic/gcr_pkg.sv ====
/*
  Types shared by the gain-control and channel-enable register group.
  Assumes gcr_map.svh is on the include path.
*/
package gcr_pkg;

  // raw register contents
  typedef struct packed {
    logic [7:0] range_enh_cfg;
    logic [7:0] level_ctl_cfg;
    logic [7:0] input_ch_en;
    logic [7:0] slot_out_en;
  } gcr_regs_s;

  // settings handed to whichever gain function is selected
  typedef struct packed {
    logic       level_ctl_sel;
    logic [6:0] level_db;
    logic [6:0] ceiling_db;
    logic       reserved_code;
  } gcr_gain_s;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gcr_req_s;

endpackage

// ==== bench/gcr_regs_assertions.sv ====
/* port assertions for the gain-control register group.
   assumes one clock and binding onto gcr_regs. */
`timescale 1ns/10ps
module gcr_regs_assertions (
  // clock, reset, inputs
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire gcr_pkg::gcr_req_s  req_in,
  input wire logic               level_ctl_sel_in,
  // outputs watched
  input wire logic [7:0]         rdata_out,
  input wire logic               rvalid_out,
  input wire gcr_pkg::gcr_regs_s regs_out,
  input wire gcr_pkg::gcr_gain_s gain_out,
  input wire logic [7:0]         input_ch_enable_out,
  input wire logic [7:0]         slot_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // outputs still hold their reset zeros at the first edge after release
  logic armed;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end
  logic [3:0] re_hi, re_lo, lc_hi, lc_lo;
  logic       sel;
  assign {re_hi, re_lo} = regs_out.range_enh_cfg;
  assign {lc_hi, lc_lo} = regs_out.level_ctl_cfg;
  assign sel = gain_out.level_ctl_sel;
  function automatic logic [7:0] rev(logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  read_answer_a: assert property (rvalid_out == $past(req_in.rd))
    else $error("read answer timing wrong");
  idle_data_a: assert property (!rvalid_out |-> rdata_out == 8'h00)
    else $error("read data not cleared");
  slot_drive_a: assert property
    (slot_oe_out == rev(regs_out.slot_out_en))
    else $error("slot drive enables wrong");
  input_enable_a: assert property
    (input_ch_enable_out == rev(regs_out.input_ch_en))
    else $error("input enables wrong");
  sel_follow_a: assert property (sel == $past(level_ctl_sel_in))
    else $error("selector not followed");
  re_level_a: assert property
    (armed && !sel |-> gain_out.level_db == 12 + 6 * re_hi)
    else $error("enhancer threshold decode wrong");
  re_ceil_a: assert property
    (armed && !sel |-> gain_out.ceiling_db == 2 + 2 * re_lo)
    else $error("enhancer ceiling decode wrong");
  lc_level_a: assert property
    (armed && sel |-> gain_out.level_db == 6 + 2 * lc_hi)
    else $error("leveler target decode wrong");
  lc_ceil_a: assert property
    (armed && sel |-> gain_out.ceiling_db == 3 + 3 * lc_lo)
    else $error("leveler ceiling decode wrong");
  reserved_flag_a: assert property (gain_out.reserved_code ==
    (sel ? lc_lo > 13 : (re_hi > 9 || re_lo > 12)))
    else $error("reserved flag wrong");
  cover property (req_in.rd && req_in.wr);
  cover property (sel && gain_out.reserved_code);
  cover property ($rose(slot_oe_out[0]));
endmodule
bind gcr_regs gcr_regs_assertions gcr_regs_assertions_i (.clk_in(clk_in),
  .rst_in(rst_in), .req_in(req_in), .level_ctl_sel_in(level_ctl_sel_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out), .regs_out(regs_out),
  .gain_out(gain_out), .input_ch_enable_out(input_ch_enable_out),
  .slot_oe_out(slot_oe_out));

// ==== bench/tb.sv ====
/* self-checking bench for gcr_regs.
   assumes the design and checker files are compiled first. */
`timescale 1ns/10ps
module tb;
  logic               clk_in = 1'b0;
  logic               rst_in = 1'b1;
  logic               level_ctl_sel_in = 1'b0;
  gcr_pkg::gcr_req_s  req_in = '0;
  logic [7:0]         rdata_out, input_ch_enable_out, slot_oe_out;
  logic               rvalid_out;
  gcr_pkg::gcr_regs_s regs_out;
  gcr_pkg::gcr_gain_s gain_out;
  int                 bad_count = 0;
  int                 cmp_count = 0;
  always #5 clk_in = ~clk_in;
  gcr_regs gcr_regs_i (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .level_ctl_sel_in(level_ctl_sel_in), .regs_out(regs_out),
    .gain_out(gain_out), .input_ch_enable_out(input_ch_enable_out),
    .slot_oe_out(slot_oe_out));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access per edge; the request is left up so no signal moves twice
  task automatic acc(logic w, r, logic [7:0] a, d, e = 8'h00);
    req_in = '{w, r, a, d};
    @(posedge clk_in);
    #1;
    if (r) chk("rdata", {rvalid_out, rdata_out}, {1'b1, e});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'b0;
    acc(0, 1, 8'h6d, 0, 8'h7b);
    acc(0, 1, 8'h70, 0, 8'he7);
    acc(0, 1, 8'h73, 0, 8'hf0);
    acc(0, 1, 8'h74, 0, 8'h00);
    chk("regs", regs_out, 32'h7be7f000);
    chk("slot_oe", slot_oe_out, 8'h00);
    chk("in_en", input_ch_enable_out, 8'h0f);
    chk("gain", gain_out, {1'b0, 7'd54, 7'd24, 1'b0});
    acc(1, 1, 8'h71, 8'hff, 8'h00);
    acc(0, 1, 8'h71, 0, 8'h00);
    acc(1, 0, 8'h73, 8'h0a);
    acc(1, 0, 8'h74, 8'h80);
    acc(1, 1, 8'h73, 8'h5f, 8'h0a);
    acc(0, 1, 8'h73, 0, 8'h5f);
    chk("slot_oe", slot_oe_out, 8'h01);
    chk("in_en", input_ch_enable_out, 8'hfa);
    for (int c = 0; c < 16; c++) begin
      acc(1, 0, 8'h6d, {c[3:0], c[3:0]});
      acc(1, 0, 8'h70, {c[3:0], c[3:0]});
      acc(0, 1, 8'h70, 0, {c[3:0], c[3:0]});
      acc(0, 1, 8'h6d, 0, {c[3:0], c[3:0]});
      chk("re_gain", gain_out, {1'b0, 7'(12+6*c), 7'(2+2*c), c > 9});
      level_ctl_sel_in = 1'b1;
      acc(0, 0, 0, 0);
      chk("lc_gain", gain_out, {1'b1, 7'(6+2*c), 7'(3+3*c), c > 13});
      level_ctl_sel_in = 1'b0;
    end
    report_and_stop();
  end
endmodule
